// [logic/ccf_defs.vh]
// Bit positions, reset values and timing counts of charger control four
`ifndef CCF_DEFS_VH
`define CCF_DEFS_VH

`define CCF_BIT_GATE_TWO 3'd7
`define CCF_BIT_GATE_ONE 3'd6
`define CCF_BIT_RATE_SEL 3'd5
`define CCF_BIT_IND_OFF 3'd4
`define CCF_BIT_SHORT_OFF 3'd3
`define CCF_BIT_UV_OFF 3'd2
`define CCF_BIT_DETECT 3'd1
`define CCF_BIT_OCP_ON 3'd0

// Reset value with the strap bit at 0; the strap is merged in at reset
`define CCF_RESET_VALUE 8'h01

// Time the converter is held off before the sample is taken, in ns
`define CCF_SETTLE_NS 1000
`define CCF_CLK_NS 10
// Settle wait in clocks: CCF_SETTLE_NS spread over CCF_CLK_NS, sized to the counter
`define CCF_SETTLE_CYCLES 8'd100
`define CCF_SETTLE_W 8

`endif

// [logic/ccf_detect_seq.v]
// Input voltage limit auto-detection sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ccf_defs.vh"

module ccf_detect_seq (
  input wire i_mclk,
  input wire i_srst,
  input wire i_start,
  input wire i_abort,
  input wire i_adc_done,
  input wire [7:0] i_adc_result,
  output reg o_switch_stop,
  output reg o_adc_start,
  output reg o_limit_we,
  output reg [7:0] o_limit_data,
  output reg o_done
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SETTLE = 4'b0010;
  localparam [3:0] ST_SAMPLE = 4'b0100;
  localparam [3:0] ST_WRITE = 4'b1000;
  localparam [`CCF_SETTLE_W-1:0] SETTLE_LAST = `CCF_SETTLE_CYCLES - 8'd1;

  reg [3:0] state;
  reg [`CCF_SETTLE_W-1:0] settle_cnt;

  // ------------------------------------------------------------
  // Sequence: stop switching, settle, sample, write back
  // ------------------------------------------------------------
  // Settling wait keeps input current from skewing the sample
  always @(posedge i_mclk) begin
    o_adc_start <= 1'b0;
    o_limit_we <= 1'b0;
    o_done <= 1'b0;
    if (i_srst || i_abort) begin
      state <= ST_IDLE;
      settle_cnt <= {`CCF_SETTLE_W{1'b0}};
      o_switch_stop <= 1'b0;
      o_limit_data <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            o_switch_stop <= 1'b1;
            settle_cnt <= {`CCF_SETTLE_W{1'b0}};
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_cnt == SETTLE_LAST) begin
            o_adc_start <= 1'b1;
            state <= ST_SAMPLE;
          end else begin
            settle_cnt <= settle_cnt + 8'd1;
          end
        end
        ST_SAMPLE: begin
          if (i_adc_done) begin
            o_limit_data <= i_adc_result;
            o_limit_we <= 1'b1;
            state <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          o_switch_stop <= 1'b0;
          o_done <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
          o_switch_stop <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [logic/ccf_control_reg.v]
// Charger control four register with strap load and detection trigger
`timescale 1ns/1ps
`default_nettype none
`include "ccf_defs.vh"

module ccf_control_reg (
  // Clock and the reset sources
  input wire i_mclk,
  input wire i_srst,
  input wire i_reg_reset,
  input wire i_watchdog_expired,
  // Host write port; reads come back on o_rd_data
  input wire i_wr_en,
  input wire [7:0] i_wr_data,
  // Board straps: strap loaded on every reset, presence on power-on only
  input wire i_programming_strap_pin,
  input wire i_input_path_pair_one,
  input wire i_input_path_pair_two,
  // Live conditions from the rest of the charger
  input wire i_all_gate_drivers_off,
  input wire i_battery_above_minimum,
  // Converter measurement handshake
  input wire i_adc_done,
  input wire [7:0] i_adc_result,
  // Register image and the field controls it drives
  output reg [7:0] o_rd_data,
  output reg o_gate_driver_two_on,
  output reg o_gate_driver_one_on,
  output reg o_switching_rate_select,
  output reg o_indicator_pin_off,
  output reg o_rail_short_hiccup_off,
  output reg o_reverse_undervolt_hiccup_off,
  output reg o_input_overcurrent_guard_on,
  // Detection controls towards the converter and the limit register
  output reg o_switch_stop,
  output reg o_adc_start,
  output reg o_input_voltage_limit_we,
  output reg [7:0] o_input_voltage_limit
);

  // ------------------------------------------------------------
  // Timing and priorities
  // ------------------------------------------------------------
  // A write is taken on the edge where i_wr_en is high; the register
  // holds it after that edge and o_rd_data and every field output show it one edge later.
  // Within one cycle the priorities are, lowest first: host write,
  // watchdog clear of the indicator bit, completion clear of the trigger,
  // then the gate driver locks. The locks come last on purpose so that
  // no write, even one in the same cycle as a lock, can ever turn an
  // unfitted or globally disabled gate driver on.
  // The trigger bit only goes from 0 to 1 through a write; a write of 0
  // while detection runs is ignored, so software cannot strand the
  // converter with switching stopped. Only completion or a reset drops it.
  // Limitation: presence of the input path pairs is sampled only under
  // the power-on reset; a pair fitted later stays locked until the next.

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Live register contents and the value it takes at the next edge
  reg [7:0] ctrl;
  reg [7:0] next_ctrl;
  // Presence of the input path pairs, frozen at power-on
  reg pair_one_fitted;
  reg pair_two_fitted;
  // One-cycle start towards the sequencer
  reg det_start;
  // Value loaded by either reset
  reg [7:0] defaults;
  // Sequencer outputs ahead of their output flops
  wire seq_stop;
  wire seq_adc_start;
  wire seq_we;
  wire [7:0] seq_data;
  wire seq_done;
  wire full_reset;

  // Either reset restores the whole register
  assign full_reset = i_srst | i_reg_reset;

  // Gate bit allowed only when its pair is fitted and no global disable
  function gate_ok;
    input fitted;
    input global_off;
    begin
      gate_ok = fitted & ~global_off;
    end
  endfunction

  // Reset image: strap decides the rate bit, the rest are constants
  always @* begin
    defaults = `CCF_RESET_VALUE;
    defaults[`CCF_BIT_RATE_SEL] = i_programming_strap_pin;
  end

  // ------------------------------------------------------------
  // Next register value
  // ------------------------------------------------------------
  // Later assignments win, which gives the priority order described above;
  // the gate locks sit at the bottom so nothing can override them
  always @* begin
    next_ctrl = ctrl;
    if (i_wr_en) begin
      next_ctrl = i_wr_data;
      // Trigger write of 1 refused unless battery is above minimum
      next_ctrl[`CCF_BIT_DETECT] = ctrl[`CCF_BIT_DETECT] |
        (i_wr_data[`CCF_BIT_DETECT] & i_battery_above_minimum);
    end
    if (i_watchdog_expired) begin
      next_ctrl[`CCF_BIT_IND_OFF] = 1'b0;
    end
    // Completion clears the trigger; a new accepted write cannot race it
    // because the trigger is already 1 until done
    if (seq_done) begin
      next_ctrl[`CCF_BIT_DETECT] = 1'b0;
    end
    if (!gate_ok(pair_two_fitted, i_all_gate_drivers_off)) begin
      next_ctrl[`CCF_BIT_GATE_TWO] = 1'b0;
    end
    if (!gate_ok(pair_one_fitted, i_all_gate_drivers_off)) begin
      next_ctrl[`CCF_BIT_GATE_ONE] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register, strap and fitted-pair capture
  // ------------------------------------------------------------
  // Presence is caught only at power-on reset; register reset keeps it
  always @(posedge i_mclk) begin
    if (i_srst) begin
      pair_one_fitted <= i_input_path_pair_one;
      pair_two_fitted <= i_input_path_pair_two;
    end
  end

  // Register reset keeps the presence flags but reloads every field,
  // the strap bit included, and drops any pending detection start
  always @(posedge i_mclk) begin
    if (full_reset) begin
      ctrl <= defaults;
      det_start <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      // Start once per rising edge of the trigger
      det_start <= next_ctrl[`CCF_BIT_DETECT] & ~ctrl[`CCF_BIT_DETECT];
    end
  end

  // ------------------------------------------------------------
  // Detection sequencer
  // ------------------------------------------------------------
  ccf_detect_seq u_seq (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_start(det_start),
    .i_abort(i_reg_reset),
    .i_adc_done(i_adc_done),
    .i_adc_result(i_adc_result),
    .o_switch_stop(seq_stop),
    .o_adc_start(seq_adc_start),
    .o_limit_we(seq_we),
    .o_limit_data(seq_data),
    .o_done(seq_done)
  );

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  // Fields mirror the register one cycle late so all outputs are flops
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_rd_data <= 8'h00;
      o_gate_driver_two_on <= 1'b0;
      o_gate_driver_one_on <= 1'b0;
      o_switching_rate_select <= 1'b0;
      o_indicator_pin_off <= 1'b0;
      o_rail_short_hiccup_off <= 1'b0;
      o_reverse_undervolt_hiccup_off <= 1'b0;
      o_input_overcurrent_guard_on <= 1'b0;
    end else begin
      o_rd_data <= ctrl;
      o_gate_driver_two_on <= ctrl[`CCF_BIT_GATE_TWO];
      o_gate_driver_one_on <= ctrl[`CCF_BIT_GATE_ONE];
      o_switching_rate_select <= ctrl[`CCF_BIT_RATE_SEL];
      o_indicator_pin_off <= ctrl[`CCF_BIT_IND_OFF];
      o_rail_short_hiccup_off <= ctrl[`CCF_BIT_SHORT_OFF];
      o_reverse_undervolt_hiccup_off <= ctrl[`CCF_BIT_UV_OFF];
      o_input_overcurrent_guard_on <= ctrl[`CCF_BIT_OCP_ON];
    end
  end

  // ------------------------------------------------------------
  // Detection outputs
  // ------------------------------------------------------------
  // Retimed as well, so the converter sees the stop request one edge
  // after the trigger shows on the read port and never before it
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_switch_stop <= 1'b0;
      o_adc_start <= 1'b0;
      o_input_voltage_limit_we <= 1'b0;
      o_input_voltage_limit <= 8'h00;
    end else begin
      o_switch_stop <= seq_stop;
      o_adc_start <= seq_adc_start;
      o_input_voltage_limit_we <= seq_we;
      o_input_voltage_limit <= seq_data;
    end
  end

endmodule
`default_nettype wire

// [testbench/ccf_control_reg_props.sv]
// Port-level assertions for the charger control four register
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module ccf_props (
  input wire i_mclk,
  input wire i_srst,
  input wire i_reg_reset,
  input wire i_watchdog_expired,
  input wire i_wr_en,
  input wire [7:0] i_wr_data,
  input wire i_programming_strap_pin,
  input wire i_input_path_pair_one,
  input wire i_input_path_pair_two,
  input wire i_all_gate_drivers_off,
  input wire i_battery_above_minimum,
  input wire i_adc_done,
  input wire [7:0] i_adc_result,
  input wire [7:0] o_rd_data,
  input wire o_gate_driver_two_on,
  input wire o_gate_driver_one_on,
  input wire o_switching_rate_select,
  input wire o_indicator_pin_off,
  input wire o_rail_short_hiccup_off,
  input wire o_reverse_undervolt_hiccup_off,
  input wire o_input_overcurrent_guard_on,
  input wire o_switch_stop,
  input wire o_adc_start,
  input wire o_input_voltage_limit_we,
  input wire [7:0] o_input_voltage_limit
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Reset value carries the strap, so it cannot be a fixed constant
  a_reset_val: assert property (
    $fell(i_srst) |=> o_rd_data == {2'b00, i_programming_strap_pin, 5'h01})
    else $error("reset value wrong");
  // Only clean writes are compared; watchdog, gate disable and absent pairs alter them
  a_write_fields: assert property (
    i_wr_en && !i_reg_reset && !i_watchdog_expired && i_input_path_pair_one
    && i_input_path_pair_two && !i_all_gate_drivers_off ##1 !i_all_gate_drivers_off
    |-> ##1 {o_gate_driver_two_on, o_gate_driver_one_on, o_switching_rate_select,
    o_indicator_pin_off, o_rail_short_hiccup_off, o_reverse_undervolt_hiccup_off, 1'b0,
    o_input_overcurrent_guard_on} == ($past(i_wr_data, 2) & 8'hfd))
    else $error("written fields wrong");
  a_gate_off: assert property (
    i_all_gate_drivers_off [*3] |-> !o_gate_driver_one_on && !o_gate_driver_two_on)
    else $error("gate driver on while disabled");
  a_pair_lock: assert property (
    (!i_input_path_pair_one |-> !o_gate_driver_one_on)
    and (!i_input_path_pair_two |-> !o_gate_driver_two_on))
    else $error("gate driver on without pair");
  a_wdog_clear: assert property (
    i_watchdog_expired |-> ##2 !o_indicator_pin_off)
    else $error("indicator bit kept over watchdog");
  a_trig_set: assert property (
    i_wr_en && i_wr_data[1] && i_battery_above_minimum && !i_reg_reset && !o_switch_stop
    |-> ##2 o_rd_data[1] ##1 o_switch_stop)
    else $error("trigger did not start detection");
  a_limit_we: assert property (
    i_adc_done && o_switch_stop && !i_reg_reset |-> ##2 o_input_voltage_limit_we
    && o_input_voltage_limit == $past(i_adc_result, 2))
    else $error("limit result wrong");
  a_trig_clear: assert property (
    o_input_voltage_limit_we |-> ##[1:3] (!o_switch_stop && !o_rd_data[1]))
    else $error("trigger not cleared");
  c_detect: cover property (o_input_voltage_limit_we);
  c_wdog: cover property (i_watchdog_expired && i_wr_en);
  c_goff: cover property (i_all_gate_drivers_off && i_wr_en);
endmodule
bind ccf_control_reg ccf_props u_props (.i_mclk, .i_srst, .i_reg_reset, .i_watchdog_expired,
  .i_wr_en, .i_wr_data, .i_programming_strap_pin, .i_input_path_pair_one,
  .i_input_path_pair_two, .i_all_gate_drivers_off, .i_battery_above_minimum, .i_adc_done,
  .i_adc_result, .o_rd_data, .o_gate_driver_two_on, .o_gate_driver_one_on,
  .o_switching_rate_select, .o_indicator_pin_off, .o_rail_short_hiccup_off,
  .o_reverse_undervolt_hiccup_off, .o_input_overcurrent_guard_on, .o_switch_stop,
  .o_adc_start, .o_input_voltage_limit_we, .o_input_voltage_limit);
`default_nettype wire

// [testbench/ccf_tb.sv]
// Self-checking bench for the charger control four register
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_mclk = 0, i_srst = 1, i_reg_reset = 0, i_watchdog_expired = 0, i_wr_en = 0;
  logic strap = 1, p1 = 1, p2 = 1, goff = 0, batt = 0, i_adc_done = 0, w;
  logic [7:0] i_wr_data = 0, i_adc_result = 0, m;
  logic [31:0] t;
  wire [7:0] rd, lim;
  wire g2, g1, rs, ind, sh, uv, ocp, stop, adc, we;
  int miscompares = 0, samples_checked = 0, k;
  integer seed = 32'hb2ce859c;
  ccf_control_reg DUT (.i_mclk, .i_srst, .i_reg_reset, .i_watchdog_expired, .i_wr_en,
    .i_wr_data, .i_programming_strap_pin(strap), .i_input_path_pair_one(p1),
    .i_input_path_pair_two(p2), .i_all_gate_drivers_off(goff),
    .i_battery_above_minimum(batt), .i_adc_done, .i_adc_result, .o_rd_data(rd),
    .o_gate_driver_two_on(g2), .o_gate_driver_one_on(g1), .o_switching_rate_select(rs),
    .o_indicator_pin_off(ind), .o_rail_short_hiccup_off(sh),
    .o_reverse_undervolt_hiccup_off(uv), .o_input_overcurrent_guard_on(ocp),
    .o_switch_stop(stop), .o_adc_start(adc), .o_input_voltage_limit_we(we),
    .o_input_voltage_limit(lim));
  always #5 i_mclk = ~i_mclk;
  // Inputs move only at the falling edge
  task cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Single output bits, kept apart from whole-byte compares
  task chk_bit(input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t bit got %b want %b", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("checked %0d bad %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for the sample request or the limit write
  task wt(input logic s);
    for (k = 0; k < 300 && !(s ? we : adc); k++)
      cyc(1);
    if (k == 300) begin
      miscompares++;
      wrap_up;
    end
  endtask
  task rst;
    i_srst = 1;
    cyc(12);
    i_srst = 0;
    cyc(2);
    chk({2'b00, strap, 5'h01}, rd);
  endtask
  // Write pulse, then two edges for the registered outputs to follow
  task wr(input logic [7:0] d, input logic wd);
    i_wr_data = d;
    i_wr_en = 1;
    i_watchdog_expired = wd;
    cyc(1);
    i_wr_en = 0;
    i_watchdog_expired = 0;
    cyc(2);
  endtask
  // Expected register after a write with the battery low
  function logic [7:0] nx(input logic [7:0] d, input logic wd);
    nx = d & 8'hfd;
    if (goff || !p1) nx[6] = 0;
    if (goff || !p2) nx[7] = 0;
    if (wd) nx[4] = 0;
  endfunction
  initial begin
    rst;
    for (int i = 0; i < 60; i++) begin
      t = $random(seed);
      goff = (i > 0) && (t[10:8] == 0);
      w = (i > 0) && (t[13:11] == 0);
      m = (i == 0) ? 8'hff : t[7:0];
      wr(m, w);
      m = nx(m, w);
      chk(m, rd);
      chk(m, {g2, g1, rs, ind, sh, uv, 1'b0, ocp});
    end
    goff = 0;
    wr(8'hfe, 0);
    i_reg_reset = 1;
    cyc(1);
    i_reg_reset = 0;
    cyc(2);
    chk(8'h21, rd);
    batt = 1;
    wr(8'h23, 0);
    chk(8'h23, rd);
    wt(0);
    chk_bit(1'b1, stop);
    t = $random(seed);
    i_adc_result = t[7:0];
    i_adc_done = 1;
    cyc(1);
    i_adc_done = 0;
    wt(1);
    chk(i_adc_result, lim);
    cyc(3);
    chk(8'h21, rd);
    chk_bit(1'b0, stop);
    chk_bit(1'b0, we);
    chk_bit(1'b0, adc);
    p1 = 0;
    p2 = 0;
    strap = 0;
    rst;
    wr(8'hc1, 0);
    chk(8'h01, rd);
    wrap_up;
  end
endmodule
`default_nettype wire
